// ===== hdl/spims_pkg.sv
// Package for the SPI master/slave port: control fields, rates, states.
// Assumes one system clock; no register bus, control bits are ports.
package spims_pkg;
   localparam int unsigned SPIMS_DATA_W = 8;
   localparam int unsigned SPIMS_BIT_CNT_W = 3;
   localparam logic [2:0] SPIMS_RATE_RSVD = 3'h7;
   localparam int unsigned SPIMS_DIV_W = 7;
   localparam logic [SPIMS_DIV_W-1:0] SPIMS_DIV_ONE = 7'h01;
   localparam logic [7:0] SPIMS_DATA_RST = 8'h00;
   localparam logic [2:0] SPIMS_BIT_LAST = 3'h7;
   localparam logic [2:0] SPIMS_BIT_FIRST = 3'h0;

   // Control word, as held by software
   typedef struct packed {
      logic spi_enable;
      logic master_select;
      logic clock_polarity;
      logic clock_phase;
      logic ss_disable;
      logic [2:0] rate_select;
   } spims_ctrl_s;

   // Status word
   typedef struct packed {
      logic transfer_done_flag;
      logic write_collision_flag;
      logic mode_fault_flag;
      logic busy;
   } spims_stat_s;

   typedef enum logic [1:0] {
      SPIMS_IDLE = 2'b00,
      SPIMS_LEAD = 2'b01,
      SPIMS_TRAIL = 2'b11
   } spims_state_e;
endpackage

// ===== hdl/spims_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to the system clock.
`timescale 1ns/1ns
module spims_sync
   import spims_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         meta_r <= '0;
         q_o <= '0;
      end
      else
      begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule

// ===== hdl/spims_top.sv
// SPI port that runs as master or slave, one byte per transfer.
// Assumes a CPU-side controller drives the control and strobe ports.
`timescale 1ns/1ns
module spims_top
   import spims_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   // Control written by software
   input wire spims_ctrl_s CTRL_WDATA_I,
   input wire logic CTRL_WR_I,
   input wire logic [7:0] DATA_WDATA_I,
   input wire logic DATA_WR_I,
   input wire logic DATA_RD_I,
   input wire logic STAT_RD_I,
   // Control and status seen by software
   output spims_ctrl_s CTRL_O,
   output spims_stat_s STAT_O,
   output logic [7:0] DATA_RDATA_O,
   output logic IRQ_O,
   // Serial pins
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE_O,
   input wire logic MOSI_I,
   output logic MOSI_O,
   output logic MOSI_OE_O,
   input wire logic MISO_I,
   output logic MISO_O,
   output logic MISO_OE_O,
   input wire logic SS_N_I
);
   logic [2:0] pins_s;
   logic sck_s, mosi_s, miso_s, ss_n_s;
   logic sck_d_r, ss_n_d_r;
   spims_state_e state_r, state_nxt;
   logic [7:0] shift_r, rx_r;
   logic [2:0] bit_r;
   logic [SPIMS_DIV_W-1:0] div_cnt_r;
   logic sample_r;
   logic mode_fault_flag_armed_r, write_collision_flag_armed_r;

   spims_sync #(.WIDTH(4)) u_sync (
      .clk_i(CLK_SYS_I),
      .srst_i(SRST_I),
      .d_i({SCK_I, MOSI_I, MISO_I, !SS_N_I}),
      .q_o({sck_s, pins_s})
   );
   assign mosi_s = pins_s[2];
   assign miso_s = pins_s[1];
   // Select held inverted so reset reads as deselected
   assign ss_n_s = !pins_s[0];

   wire is_master = CTRL_O.spi_enable && CTRL_O.master_select;
   wire is_slave = CTRL_O.spi_enable && !CTRL_O.master_select;
   // Select ignored as GPIO in master with ss_disable
   wire mode_fault_flag_det = is_master && !CTRL_O.ss_disable && !ss_n_s;
   wire slave_sel = CTRL_O.ss_disable && CTRL_O.clock_phase
                    ? 1'b1 : !ss_n_s;
   wire sel_fall = ss_n_d_r && !ss_n_s;
   wire busy = (state_r != SPIMS_IDLE);
   // Half-period count: div/2, code 7 gives no clock
   wire rate_ok = (CTRL_O.rate_select != SPIMS_RATE_RSVD);
   wire [SPIMS_DIV_W-1:0] half_div =
      SPIMS_DIV_ONE << CTRL_O.rate_select;
   wire tick = is_master && rate_ok && (div_cnt_r == half_div);
   // Slave clock edges, polarity removed
   wire sck_rise = is_slave && slave_sel && !sck_d_r && sck_s;
   wire sck_fall = is_slave && slave_sel && sck_d_r && !sck_s;
   wire lead_edge = CTRL_O.clock_polarity ? sck_fall : sck_rise;
   wire trail_edge = CTRL_O.clock_polarity ? sck_rise : sck_fall;
   wire m_edge = tick && busy;
   wire samp_edge = CTRL_O.clock_phase ? trail_edge : lead_edge;
   wire shft_edge = CTRL_O.clock_phase ? lead_edge : trail_edge;
   wire rx_bit = is_master ? miso_s : mosi_s;
   wire start_m = is_master && DATA_WR_I && !busy;
   wire start_s0 = is_slave && !CTRL_O.clock_phase && sel_fall;
   wire start_s1 = is_slave && CTRL_O.clock_phase && lead_edge
                   && !busy;
   wire write_collision_flag_set = DATA_WR_I && busy;
   wire last_bit = (bit_r == SPIMS_BIT_LAST);
   // Phase one slave: no ninth leading edge, close on last sample
   wire shft_go = shft_edge
                  || (is_slave && CTRL_O.clock_phase && last_bit);

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         SPIMS_IDLE:
            if (start_m || start_s0 || start_s1)
               state_nxt = SPIMS_LEAD;
         SPIMS_LEAD:
            if (m_edge || (!is_master && samp_edge))
               state_nxt = SPIMS_TRAIL;
         SPIMS_TRAIL:
            if (m_edge || (!is_master && shft_go))
               state_nxt = last_bit ? SPIMS_IDLE : SPIMS_LEAD;
         default:
            state_nxt = SPIMS_IDLE;
      endcase
      if (!CTRL_O.spi_enable || mode_fault_flag_det)
         state_nxt = SPIMS_IDLE;
      if (is_slave && !CTRL_O.clock_phase && ss_n_s)
         state_nxt = SPIMS_IDLE;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         state_r <= SPIMS_IDLE;
         sck_d_r <= 1'b0;
         ss_n_d_r <= 1'b1;
         div_cnt_r <= SPIMS_DIV_ONE;
      end
      else
      begin
         state_r <= state_nxt;
         sck_d_r <= sck_s;
         ss_n_d_r <= ss_n_s;
         div_cnt_r <= (tick || !busy) ? SPIMS_DIV_ONE
                      : div_cnt_r + SPIMS_DIV_ONE;
      end
   end

   // Shift register, bit counter, receive buffer
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         shift_r <= SPIMS_DATA_RST;
         rx_r <= SPIMS_DATA_RST;
         bit_r <= SPIMS_BIT_FIRST;
         sample_r <= 1'b0;
      end
      else if (state_r == SPIMS_IDLE)
      begin
         bit_r <= SPIMS_BIT_FIRST;
         if (DATA_WR_I)
            shift_r <= DATA_WDATA_I;
         if (CTRL_O.clock_phase && start_s1)
            sample_r <= 1'b0;
      end
      else
      begin
         if ((state_r == SPIMS_LEAD) && (m_edge || samp_edge))
            sample_r <= rx_bit;
         if ((state_r == SPIMS_TRAIL) && (m_edge || shft_go))
         begin
            shift_r <= {shift_r[6:0], sample_r};
            bit_r <= bit_r + 3'h1;
            if (last_bit)
               rx_r <= {shift_r[6:0], sample_r};
         end
      end
   end

   // Control, flags and pins
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         CTRL_O <= '0;
         STAT_O <= '0;
         mode_fault_flag_armed_r <= 1'b0;
         write_collision_flag_armed_r <= 1'b0;
         IRQ_O <= 1'b0;
         DATA_RDATA_O <= SPIMS_DATA_RST;
         SCK_O <= 1'b0;
         SCK_OE_O <= 1'b0;
         MOSI_O <= 1'b0;
         MOSI_OE_O <= 1'b0;
         MISO_O <= 1'b0;
         MISO_OE_O <= 1'b0;
      end
      else
      begin
         if (CTRL_WR_I)
            CTRL_O <= CTRL_WDATA_I;
         if (mode_fault_flag_det)
         begin
            CTRL_O.spi_enable <= 1'b0;
            CTRL_O.master_select <= 1'b0;
         end
         // Fault flag clears: status read then control write; collision flag clears: status read then data write or read
         if (STAT_RD_I && STAT_O.mode_fault_flag)
            mode_fault_flag_armed_r <= 1'b1;
         if (STAT_RD_I && STAT_O.write_collision_flag)
            write_collision_flag_armed_r <= 1'b1;
         if (mode_fault_flag_det)
            STAT_O.mode_fault_flag <= 1'b1;
         else if (mode_fault_flag_armed_r && CTRL_WR_I)
         begin
            STAT_O.mode_fault_flag <= 1'b0;
            mode_fault_flag_armed_r <= 1'b0;
         end
         if (write_collision_flag_set)
            STAT_O.write_collision_flag <= 1'b1;
         else if (write_collision_flag_armed_r && (DATA_WR_I || DATA_RD_I))
         begin
            STAT_O.write_collision_flag <= 1'b0;
            write_collision_flag_armed_r <= 1'b0;
         end
         if (busy && state_nxt == SPIMS_IDLE && last_bit
             && state_r == SPIMS_TRAIL)
         begin
            STAT_O.transfer_done_flag <= 1'b1;
            DATA_RDATA_O <= {shift_r[6:0], sample_r};
         end
         else if (DATA_RD_I || DATA_WR_I)
            STAT_O.transfer_done_flag <= 1'b0;
         STAT_O.busy <= (state_nxt != SPIMS_IDLE);
         IRQ_O <= STAT_O.mode_fault_flag || mode_fault_flag_det
                  || STAT_O.transfer_done_flag;
         SCK_OE_O <= is_master && !mode_fault_flag_det;
         MOSI_OE_O <= is_master && !mode_fault_flag_det;
         SCK_O <= CTRL_O.clock_polarity ^ (is_master && state_nxt ==
                  (CTRL_O.clock_phase ? SPIMS_LEAD : SPIMS_TRAIL)
                  && (state_r != SPIMS_IDLE || CTRL_O.clock_phase));
         MOSI_O <= shift_r[7];
         MISO_O <= shift_r[7];
         MISO_OE_O <= is_slave && slave_sel;
      end
   end
endmodule

// ===== tb/spims_peer.sv
// Behavioural slave peer, clock phase and polarity zero.
// Assumes its select is raised between bytes to reload.
`timescale 1ns/1ns
module spims_peer
#(
   parameter logic [7:0] TX_BYTE = 8'h3C
)
(
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic sel_n_i,
   output logic miso_o,
   output logic [7:0] rx_o
);
   logic [7:0] tx_r = TX_BYTE;
   // Capture on leading edge, MSB first
   always @(posedge sck_i)
      rx_o <= {rx_o[6:0], mosi_i};
   // Next bit on trailing edge
   always @(negedge sck_i)
      if (!sel_n_i)
         tx_r <= {tx_r[6:0], !tx_r[0]};
   always @(posedge sel_n_i)
      tx_r <= TX_BYTE;
   // First bit before first edge; released line inverted
   assign miso_o = sel_n_i ? !tx_r[7] : tx_r[7];
endmodule

// ===== tb/spims_sva.sv
// Checker on the SPI port top-level ports.
// Assumes bind onto spims_top; one clock domain.
`timescale 1ns/1ns
module spims_sva
   import spims_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   input wire logic DATA_WR_I,
   input wire logic SS_N_I,
   input wire spims_ctrl_s CTRL_O,
   input wire spims_stat_s STAT_O,
   input wire logic IRQ_O,
   input wire logic SCK_O,
   input wire logic MISO_OE_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   logic [4:0] tog_r;
   logic sck_r;
   wire mst = CTRL_O.master_select & CTRL_O.spi_enable;
   wire off = !CTRL_O.master_select & SS_N_I
      & !(CTRL_O.clock_phase & CTRL_O.ss_disable);
   // Clock toggles since the last start
   always_ff @(posedge CLK_SYS_I)
   begin
      sck_r <= SCK_O;
      tog_r <= (DATA_WR_I & !STAT_O.busy) ? 5'h00
         : tog_r + {4'h0, SCK_O ^ sck_r};
   end
   sequence s_ss_disable;
      mst && CTRL_O.ss_disable && !STAT_O.mode_fault_flag;
   endsequence
   sequence s_end;
      $fell(STAT_O.busy) && mst;
   endsequence
   chk_eight_clocks: assert property (s_end |-> ##2 tog_r == 5'h10)
      else $error("master clock count wrong");
   chk_idle_polarity: assert property ((mst && !STAT_O.busy)[*3]
      |-> SCK_O == CTRL_O.clock_polarity)
      else $error("idle clock level wrong");
   chk_slave_float: assert property (off[*4] |-> !MISO_OE_O)
      else $error("unselected slave drives line");
   chk_fault_clears: assert property ($rose(STAT_O.mode_fault_flag)
      |-> ##[0:2] !CTRL_O.spi_enable && !CTRL_O.master_select)
      else $error("fault left port enabled");
   chk_fault_irq: assert property (STAT_O.mode_fault_flag |-> ##[0:1] IRQ_O)
      else $error("fault without interrupt");
   chk_write_collision_flag_set: assert property (DATA_WR_I && STAT_O.busy
      |-> ##[1:2] STAT_O.write_collision_flag)
      else $error("collision flag not set");
   chk_nofault_ss_disable: assert property (s_ss_disable ##1
      (mst && CTRL_O.ss_disable) |-> !STAT_O.mode_fault_flag)
      else $error("fault with select ignored");
   chk_rate_rsvd: assert property (mst && STAT_O.busy
      && CTRL_O.rate_select == SPIMS_RATE_RSVD |=> $stable(SCK_O))
      else $error("reserved rate ticks");
endmodule
bind spims_top spims_sva spims_sva_inst (
   .CLK_SYS_I(CLK_SYS_I),
   .SRST_I(SRST_I),
   .DATA_WR_I(DATA_WR_I),
   .SS_N_I(SS_N_I),
   .CTRL_O(CTRL_O),
   .STAT_O(STAT_O),
   .IRQ_O(IRQ_O),
   .SCK_O(SCK_O),
   .MISO_OE_O(MISO_OE_O)
);

// ===== tb/spims_top_tb_top.sv
// Testbench for the SPI port: transfers, collision, faults.
// Assumes spims_peer on the far side and a bound checker.
`timescale 1ns/1ns
module spims_top_tb_top
   import spims_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] wdata = 8'h00;
   logic ctrl_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0, stat_rd = 1'b0;
   logic ss_n = 1'b1, peer_sel_n = 1'b1;
   spims_ctrl_s ctrl_o;
   spims_stat_s stat_o;
   logic [7:0] rdata, peer_rx;
   logic irq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, peer_miso;
   int bad_count = 0, checked = 0, cycles = 0;
   spims_top spims_top_inst (.CLK_SYS_I(clk), .SRST_I(srst),
      .CTRL_WDATA_I(wdata), .CTRL_WR_I(ctrl_wr), .DATA_WDATA_I(wdata),
      .DATA_WR_I(data_wr), .DATA_RD_I(data_rd), .STAT_RD_I(stat_rd),
      .CTRL_O(ctrl_o), .STAT_O(stat_o), .DATA_RDATA_O(rdata), .IRQ_O(irq),
      .SCK_I(sck_oe ? sck : 1'b0), .SCK_O(sck), .SCK_OE_O(sck_oe),
      .MOSI_I(mosi_oe ? mosi : 1'b0), .MOSI_O(mosi), .MOSI_OE_O(mosi_oe),
      .MISO_I(miso_oe ? miso : peer_miso), .MISO_O(miso),
      .MISO_OE_O(miso_oe), .SS_N_I(ss_n));
   spims_peer spims_peer_inst (.sck_i(sck), .mosi_i(mosi),
      .sel_n_i(peer_sel_n), .miso_o(peer_miso), .rx_o(peer_rx));
   initial forever #2 clk = ~clk;
   task automatic test_done;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         test_done();
      end
   end
   task automatic cmp(input string nm, input logic [7:0] e, g);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   // Strobes: ctrl write, data write, data read, status read
   task automatic pulse(input logic [3:0] s, input logic [7:0] v);
      @(posedge clk);
      wdata <= v;
      {ctrl_wr, data_wr, data_rd, stat_rd} <= s;
      @(posedge clk);
      {ctrl_wr, data_wr, data_rd, stat_rd} <= 4'h0;
   endtask
   task automatic wait_done;
      repeat (2000)
      begin
         @(negedge clk);
         if (stat_o.transfer_done_flag === 1'b1)
            break;
      end
   endtask
   task automatic t_master;
      pulse(4'h8, 8'hCB);
      peer_sel_n <= 1'b0;
      pulse(4'h4, 8'hA5);
      wait_done();
      cmp("rx", 8'h3C, rdata);
      cmp("peer rx", 8'hA5, peer_rx);
      cmp("sck oe", 8'h01, sck_oe);
      pulse(4'h2, 8'h00);
      peer_sel_n <= 1'b1;
   endtask
   task automatic t_write_collision_flag;
      @(posedge clk);
      peer_sel_n <= 1'b0;
      pulse(4'h4, 8'h5A);
      repeat (20) @(posedge clk);
      pulse(4'h4, 8'hFF);
      @(negedge clk);
      cmp("write_collision_flag", 8'h01, stat_o.write_collision_flag);
      wait_done();
      cmp("peer rx", 8'h5A, peer_rx);
      cmp("rx", 8'h3C, rdata);
      pulse(4'h1, 8'h00);
      pulse(4'h2, 8'h00);
      @(negedge clk);
      cmp("write_collision_flag", 8'h00, stat_o.write_collision_flag);
      peer_sel_n <= 1'b1;
   endtask
   task automatic t_ss_disable;
      @(posedge clk);
      ss_n <= 1'b0;
      repeat (8) @(negedge clk);
      cmp("mode_fault_flag", 8'h00, stat_o.mode_fault_flag);
      @(posedge clk);
      ss_n <= 1'b1;
      pulse(4'h8, 8'h83);
      repeat (6) @(negedge clk);
      cmp("miso oe", 8'h00, miso_oe);
   endtask
   task automatic t_fault;
      pulse(4'h8, 8'hC3);
      ss_n <= 1'b0;
      repeat (8) @(negedge clk);
      cmp("mode_fault_flag", 8'h01, stat_o.mode_fault_flag);
      cmp("sck oe", 8'h00, sck_oe);
      @(posedge clk);
      ss_n <= 1'b1;
      cmp("ctrl", 8'h03, ctrl_o);
      cmp("irq", 8'h01, irq);
      pulse(4'h8, 8'h0B);
      pulse(4'h8, 8'h03);
      @(negedge clk);
      cmp("mode_fault_flag", 8'h01, stat_o.mode_fault_flag);
      pulse(4'h1, 8'h00);
      pulse(4'h8, 8'h03);
      @(negedge clk);
      cmp("mode_fault_flag", 8'h00, stat_o.mode_fault_flag);
   endtask
   task automatic t_rsvd;
      pulse(4'h8, 8'hCF);
      pulse(4'h4, 8'h11);
      repeat (40) @(negedge clk);
      cmp("busy", 8'h01, stat_o.busy);
      pulse(4'h8, 8'h0B);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_master();
      t_write_collision_flag();
      t_ss_disable();
      t_fault();
      t_rsvd();
      test_done();
   end
endmodule
